// ### logic/program_jog_sequencer.sv
// Program jog sequencer core
`timescale 1ns/1ps
`default_nettype none
`include "program_jog_defs.svh"

// Overview of operation
// - Pattern 0..5, default 0, applies live
// - Patterns 0/1: wait then one-way move
// - Pattern 2: forward cycles, then reverse cycles
// - Pattern 3: reverse cycles, then forward cycles
// - Pattern 4: wait, forward, wait, reverse
// - Pattern 5: wait, reverse, wait, forward
// - Distance 1..2^30, default 32768, live
// - Speed 1..10000 mm/s, default 50
// - Ramp 2..10000 ms, default 100
// - Wait 0..10000 ms, default 100
// - Count zero endless for patterns 0,1,4,5
// - Endless keeps the selected pattern
// - Patterns 2,3 never endless
// - Servo toggle key ends endless run
// - Run only when servo ready
// - Overtravel blocks motion that direction
// - Absolute encoder forces sensor on
// - Direction select flips forward sense
// - Start key held one second, then wait
// - Servo off mid-move gives base block
// - End status one second, then run
// - Write protect or servo on: no-op
module program_jog_sequencer #(
    parameter int MS_CYCLES = `JOG_MS_CYCLES,
    parameter int HOLD_MS = `JOG_HOLD_MS,
    parameter int END_MS = `JOG_END_MS
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic enterFunction,
    input wire logic writeProtect,
    input wire logic servoReady,
    input wire logic servoToggleKey,
    input wire logic fwdStartKey,
    input wire logic revStartKey,
    input wire logic fwdOvertravel,
    input wire logic revOvertravel,
    input wire logic absEncoder,
    input wire logic sensorOnInput,
    input wire logic directionSelect,
    input wire logic moveDone,
    input wire logic [2:0] jogPatternSelect,
    input wire logic [30:0] jogMoveDistance,
    input wire logic [13:0] jogMoveSpeed,
    input wire logic [13:0] jogRampTime,
    input wire logic [13:0] jogWaitTime,
    input wire logic [15:0] jogRepeatCount,
    output logic servoOn,
    output logic moveStart,
    output logic moveDirUp,
    output logic [30:0] moveDistance,
    output logic [13:0] moveSpeed,
    output logic [13:0] moveRamp,
    output logic moveStop,
    output logic sensorOnOut,
    output logic functionActive,
    output logic noOpStatus,
    output logic endStatus,
    output logic runStatus,
    output logic [15:0] repeatDone
);
    if (MS_CYCLES < 1 || MS_CYCLES > 33554432 || HOLD_MS < 1 ||
        HOLD_MS > 1024 || END_MS < 1 || END_MS > 1024)
    begin : badTiming
        $error("Timing parameters out of range");
    end
    logic [1:0] rstSync;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rstSync <= '0;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    wire logic rstnInt = rstSync[1];

    // Two-flop synchronisers for pins, then key edge
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] pinRaw, pinMeta, pinSync;
    logic sEnter, sProtect, sReady, sToggle, sFwdKey, sRevKey;
    logic sFwdOt, sRevOt, sAbs, sSen, sDirSel, toggleDly;
    assign pinRaw = {enterFunction, writeProtect, servoReady, servoToggleKey,
                     fwdStartKey, revStartKey, fwdOvertravel, revOvertravel,
                     absEncoder, sensorOnInput, directionSelect};
    assign {sEnter, sProtect, sReady, sToggle, sFwdKey, sRevKey, sFwdOt,
            sRevOt, sAbs, sSen, sDirSel} = pinSync;
    always_ff @(posedge core_clk or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            pinMeta <= '0;
            pinSync <= '0;
            toggleDly <= 1'b0;
        end
        else
        begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            toggleDly <= sToggle;
        end
    end
    wire logic togglePress = sToggle & ~toggleDly;

    // Millisecond tick, restarted when the end timer starts
    logic msClr;
    logic [24:0] msDiv;
    wire logic msTick = (msDiv == 25'(MS_CYCLES - 1)) && !msClr;
    always_ff @(posedge core_clk or negedge rstnInt)
    begin
        if (!rstnInt)
            msDiv <= '0;
        else if (msClr || msTick)
            msDiv <= '0;
        else
            msDiv <= msDiv + 25'h0000001;
    end

    // Pattern clamp, live value
    function automatic logic [2:0] clampPat(input logic [2:0] p);
        return (p > `JOG_PAT_MAX) ? `JOG_PAT_DEF : p;
    endfunction
    function automatic logic [13:0] clamp14(input logic [13:0] v,
                                            input logic [13:0] lo,
                                            input logic [13:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction
    wire logic [2:0] pat = clampPat(jogPatternSelect);
    // Endless only for patterns 0,1,4,5
    wire logic endless = (jogRepeatCount == 16'h0000) &&
                         (pat != 3'h2) && (pat != 3'h3);

    // Phase 0 = first leg; phase 1 = second leg
    function automatic logic legForward(input logic [2:0] p,
                                        input logic ph);
        unique case (p)
            3'h0: legForward = 1'b1;
            3'h1: legForward = 1'b0;
            3'h2: legForward = ~ph;
            3'h3: legForward = ph;
            3'h4: legForward = ~ph;
            default: legForward = ph;
        endcase
    endfunction
    program_jog_pkg::jog_state_t state;
    logic phase;
    logic [15:0] cycleCnt;
    logic [13:0] waitCnt;
    logic [9:0] holdCnt;
    logic [9:0] endCnt;
    wire logic firstFwd = legForward(pat, 1'b0);
    wire logic curFwd = legForward(pat, phase);
    wire logic lastCycle = !endless && (cycleCnt + 16'h0001 >= jogRepeatCount);
    wire logic twoLeg = (pat == 3'h4) || (pat == 3'h5);
    wire logic seqPat = (pat == 3'h2) || (pat == 3'h3);
    wire logic startKey = firstFwd ? sFwdKey : sRevKey;
    wire logic otBlock = curFwd ? sFwdOt : sRevOt;
    wire logic servoLost = !sReady || !sEnter;
    always_ff @(posedge core_clk or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            state <= program_jog_pkg::ST_IDLE;
            servoOn <= 1'b0;
            functionActive <= 1'b0;
            noOpStatus <= 1'b0;
            phase <= 1'b0;
            cycleCnt <= '0;
            waitCnt <= '0;
            holdCnt <= '0;
            endCnt <= '0;
            moveStart <= 1'b0;
            moveStop <= 1'b0;
            endStatus <= 1'b0;
            msClr <= 1'b0;
        end
        else
        begin
            moveStart <= 1'b0;
            moveStop <= 1'b0;
            msClr <= 1'b0;
            unique case (state)
                program_jog_pkg::ST_IDLE:
                begin
                    servoOn <= 1'b0;
                    functionActive <= 1'b0;
                    endStatus <= 1'b0;
                    noOpStatus <= sEnter && (sProtect || servoOn);
                    if (sEnter && !sProtect && !servoOn)
                    begin
                        functionActive <= 1'b1;
                        state <= program_jog_pkg::ST_READY;
                    end
                end
                program_jog_pkg::ST_READY:
                begin
                    noOpStatus <= 1'b0;
                    endStatus <= 1'b0;
                    if (!sEnter)
                    begin
                        servoOn <= 1'b0;
                        state <= program_jog_pkg::ST_IDLE;
                    end
                    else if (togglePress)
                        servoOn <= !servoOn && sReady;
                    if (servoOn && sEnter && startKey && !togglePress)
                    begin
                        if (msTick && holdCnt == 10'(HOLD_MS - 1))
                        begin
                            holdCnt <= '0;
                            phase <= 1'b0;
                            cycleCnt <= '0;
                            waitCnt <= '0;
                            state <= program_jog_pkg::ST_WAIT;
                        end
                        else if (msTick)
                            holdCnt <= holdCnt + 10'h001;
                    end
                    else
                        holdCnt <= '0;
                end
                program_jog_pkg::ST_WAIT:
                begin
                    if (togglePress || servoLost)
                    begin
                        servoOn <= 1'b0;
                        state <= program_jog_pkg::ST_READY;
                    end
                    else if (waitCnt >= clamp14(jogWaitTime, 14'h0000,
                                                `JOG_WAIT_MAX))
                    begin
                        if (!otBlock)
                        begin
                            moveStart <= 1'b1;
                            state <= program_jog_pkg::ST_MOVE;
                        end
                    end
                    else if (msTick)
                        waitCnt <= waitCnt + 14'h0001;
                end
                program_jog_pkg::ST_MOVE:
                begin
                    waitCnt <= '0;
                    if (togglePress || servoLost)
                    begin
                        servoOn <= 1'b0;
                        moveStop <= 1'b1;
                        state <= program_jog_pkg::ST_READY;
                    end
                    else if (otBlock)
                    begin
                        moveStop <= 1'b1;
                        state <= program_jog_pkg::ST_WAIT;
                    end
                    else if (moveDone)
                    begin
                        if (twoLeg && !phase)
                        begin
                            phase <= 1'b1;
                            state <= program_jog_pkg::ST_WAIT;
                        end
                        else if (lastCycle && (!seqPat || phase))
                        begin
                            cycleCnt <= cycleCnt + 16'h0001;
                            endCnt <= '0;
                            msClr <= 1'b1;
                            endStatus <= 1'b1;
                            state <= program_jog_pkg::ST_END;
                        end
                        else if (lastCycle && seqPat)
                        begin
                            cycleCnt <= '0;
                            phase <= 1'b1;
                            state <= program_jog_pkg::ST_WAIT;
                        end
                        else
                        begin
                            cycleCnt <= cycleCnt + 16'h0001;
                            if (twoLeg)
                                phase <= 1'b0;
                            state <= program_jog_pkg::ST_WAIT;
                        end
                    end
                end
                program_jog_pkg::ST_END:
                begin
                    if (togglePress || servoLost)
                    begin
                        servoOn <= 1'b0;
                        endStatus <= 1'b0;
                        state <= program_jog_pkg::ST_READY;
                    end
                    else if (msTick && endCnt == 10'(END_MS - 1))
                    begin
                        endStatus <= 1'b0;
                        state <= program_jog_pkg::ST_READY;
                    end
                    else if (msTick)
                        endCnt <= endCnt + 10'h001;
                end
            endcase
        end
    end
    // Move command outputs
    always_ff @(posedge core_clk or negedge rstnInt)
    begin
        if (!rstnInt)
        begin
            moveDirUp <= 1'b1;
            moveDistance <= `JOG_DIST_DEF;
            moveSpeed <= `JOG_SPEED_DEF;
            moveRamp <= `JOG_RAMP_DEF;
            sensorOnOut <= 1'b0;
            runStatus <= 1'b0;
            repeatDone <= '0;
        end
        else
        begin
            moveDirUp <= curFwd ~^ sDirSel;
            moveDistance <= (jogMoveDistance == 31'h00000000) ? 31'h00000001 :
                ((jogMoveDistance > `JOG_DIST_MAX) ? `JOG_DIST_MAX
                 : jogMoveDistance);
            moveSpeed <= clamp14(jogMoveSpeed, 14'h0001,
                                 `JOG_SPEED_MAX);
            moveRamp <= clamp14(jogRampTime, `JOG_RAMP_MIN,
                                `JOG_RAMP_MAX);
            sensorOnOut <= functionActive && (sAbs || sSen);
            runStatus <= servoOn && !endStatus;
            repeatDone <= cycleCnt;
        end
    end
endmodule
`default_nettype wire

// ### logic/program_jog_defs.svh
// Constants for the program jog sequencer
`ifndef PROGRAM_JOG_DEFS_SVH
`define PROGRAM_JOG_DEFS_SVH
`define JOG_CLK_HZ 25000000
`define JOG_MS_CYCLES (`JOG_CLK_HZ / 1000)
`define JOG_END_MS 1000
`define JOG_HOLD_MS 1000
`define JOG_PAT_MAX 3'h5
`define JOG_PAT_DEF 3'h0
`define JOG_DIST_DEF 31'h00008000
`define JOG_DIST_MAX 31'h40000000
`define JOG_SPEED_DEF 14'h0032
`define JOG_SPEED_MAX 14'h2710
`define JOG_RAMP_DEF 14'h0064
`define JOG_RAMP_MIN 14'h0002
`define JOG_RAMP_MAX 14'h2710
`define JOG_WAIT_DEF 14'h0064
`define JOG_WAIT_MAX 14'h2710
`endif

// ### logic/program_jog_pkg.sv
// Types for the program jog sequencer
package program_jog_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_WAIT,
        ST_MOVE,
        ST_END
    } jog_state_t;
endpackage

// ### tb/program_jog_sequencer_checker.sv
// Port assertions for the program jog sequencer
`timescale 1ns/1ps
`default_nettype none
module program_jog_sequencer_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic fwdOvertravel,
    input wire logic revOvertravel,
    input wire logic directionSelect,
    input wire logic moveStart,
    input wire logic moveDirUp,
    input wire logic [30:0] moveDistance,
    input wire logic [13:0] moveSpeed,
    input wire logic [13:0] moveRamp,
    input wire logic moveStop,
    input wire logic servoOn,
    input wire logic functionActive,
    input wire logic noOpStatus,
    input wire logic endStatus,
    input wire logic runStatus
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    logic fwdMove;
    assign fwdMove = moveDirUp ~^ directionSelect;
    chk_start_servo_on: assert property (moveStart |-> servoOn)
        else $error("move start without servo on");
    chk_fwd_ot_block: assert property (fwdOvertravel[*6] |->
        !(moveStart && fwdMove)) else $error("forward move while blocked");
    chk_rev_ot_block: assert property (revOvertravel[*6] |->
        !(moveStart && !fwdMove)) else $error("reverse move while blocked");
    chk_start_one_cycle: assert property (moveStart |=> !moveStart)
        else $error("move start longer than one cycle");
    chk_stop_one_cycle: assert property (moveStop |=> !moveStop)
        else $error("move stop longer than one cycle");
    chk_run_status: assert property (runStatus ==
        ($past(servoOn) && !$past(endStatus)))
        else $error("run status does not follow servo and end");
    chk_noop_idle: assert property (noOpStatus |->
        !servoOn && !functionActive)
        else $error("no-op status with function active");
    chk_speed_range: assert property (moveSpeed inside {[1:10000]})
        else $error("move speed out of range");
    chk_ramp_range: assert property (moveRamp inside {[2:10000]})
        else $error("ramp time out of range");
    chk_dist_range: assert property (moveDistance inside
        {[1:1073741824]}) else $error("move distance out of range");
    cov_move: cover property (moveStart);
    cov_abort: cover property (moveStop);
    cov_end: cover property ($rose(endStatus));
    cov_noop: cover property (noOpStatus);
endmodule
`default_nettype wire

// ### tb/position_loop_model.sv
// Position loop model answering move requests
`timescale 1ns/1ps
`default_nettype none
module position_loop_model (
    input wire logic core_clk,
    input wire logic moveStart,
    input wire logic moveStop,
    input wire logic [7:0] doneDelay,
    output logic moveDone
);
    logic [7:0] cnt = 8'h00;
    logic busy = 1'b0;
    initial moveDone = 1'b0;
    always @(posedge core_clk)
    begin
        moveDone <= 1'b0;
        if (moveStop)
            busy <= 1'b0;
        else if (moveStart)
        begin
            busy <= 1'b1;
            cnt <= doneDelay;
        end
        else if (busy && cnt == 8'h00)
        begin
            busy <= 1'b0;
            moveDone <= 1'b1;
        end
        else if (busy)
            cnt <= cnt - 8'h01;
    end
endmodule
`default_nettype wire

// ### tb/program_jog_sequencer_bench.sv
// Self-checking bench for the program jog sequencer
`timescale 1ns/1ps
`default_nettype none
module program_jog_sequencer_bench;
    localparam int MS = 4;
    logic core_clk = 1'b0, rstn = 1'b0, enterFunction = 1'b0;
    logic writeProtect = 1'b0, servoReady = 1'b1, servoToggleKey = 1'b0;
    logic fwdStartKey = 1'b0, revStartKey = 1'b0, fwdOvertravel = 1'b0;
    logic revOvertravel = 1'b0, absEncoder = 1'b1, sensorOnInput = 1'b0;
    logic directionSelect = 1'b1, moveDone, stopSeen = 1'b0;
    logic [2:0] jogPatternSelect = 3'h0;
    logic [30:0] jogMoveDistance = 31'h00000064, moveDistance;
    logic [13:0] jogMoveSpeed = 14'h0010, jogRampTime = 14'h0002;
    logic [13:0] jogWaitTime = 14'h0003, moveSpeed, moveRamp;
    logic [15:0] jogRepeatCount = 16'h0002, repeatDone;
    logic servoOn, moveStart, moveDirUp, moveStop, sensorOnOut;
    logic functionActive, noOpStatus, endStatus, runStatus;
    logic [7:0] doneDelay = 8'h06;
    logic q [$];
    int err_count = 0, checks = 0;
    always #20 core_clk = ~core_clk;
    program_jog_sequencer #(.MS_CYCLES(MS), .HOLD_MS(2), .END_MS(2)) i_dut (
        .core_clk, .rstn, .enterFunction, .writeProtect, .servoReady,
        .servoToggleKey, .fwdStartKey, .revStartKey, .fwdOvertravel,
        .revOvertravel, .absEncoder, .sensorOnInput, .directionSelect,
        .moveDone, .jogPatternSelect, .jogMoveDistance, .jogMoveSpeed,
        .jogRampTime, .jogWaitTime, .jogRepeatCount, .servoOn, .moveStart,
        .moveDirUp, .moveDistance, .moveSpeed, .moveRamp, .moveStop,
        .sensorOnOut, .functionActive, .noOpStatus, .endStatus, .runStatus,
        .repeatDone
    );
    position_loop_model i_loop (.core_clk, .moveStart, .moveStop,
        .doneDelay, .moveDone);
    always @(negedge core_clk)
    begin
        if (moveStart === 1'b1)
            q.push_back(moveDirUp);
        if (moveStop === 1'b1)
            stopSeen = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic mid;
        @(negedge core_clk);
    endtask
    task automatic check_val(input logic [30:0] got, input logic [30:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic press;
        tick(1);
        servoToggleKey <= 1'b1;
        tick(4);
        servoToggleKey <= 1'b0;
        tick(4);
        mid;
    endtask
    task automatic begin_run(input logic [2:0] pat, input logic [15:0] cnt);
        tick(1);
        q.delete();
        jogPatternSelect <= pat;
        jogRepeatCount <= cnt;
        enterFunction <= 1'b1;
        tick(6);
        press();
        check_val(servoOn, 1'b1);
        check_val(sensorOnOut, 1'b1);
        tick(1);
        if (pat[0])
            revStartKey <= 1'b1;
        else
            fwdStartKey <= 1'b1;
        tick(2 * MS + 6);
        fwdStartKey <= 1'b0;
        revStartKey <= 1'b0;
        mid;
        check_val(31'(q.size()), 31'h0);
    endtask
    task automatic wait_moves(input int n);
        int k;
        k = 0;
        while (q.size() < n && k < 3000)
        begin
            mid;
            k++;
        end
    endtask
    task automatic check_dirs(input logic [2:0] pat, input int n);
        logic f;
        check_val(31'(q.size()), 31'(n));
        for (int i = 0; i < q.size() && i < n; i++)
        begin
            case (pat)
                3'h0: f = 1'b1;
                3'h1: f = 1'b0;
                3'h2: f = i < n / 2;
                3'h3: f = i >= n / 2;
                default: f = pat[0] ^ ~i[0];
            endcase
            f = f ~^ directionSelect;
            check_val(q[i], f);
        end
    endtask
    task automatic finish_run(input logic [2:0] pat, input int n, input int r);
        int len;
        wait_moves(n);
        len = 0;
        while (endStatus !== 1'b1 && len < 300)
        begin
            mid;
            len++;
        end
        check_dirs(pat, n);
        len = 0;
        while (endStatus === 1'b1 && len < 100)
        begin
            mid;
            len++;
        end
        mid;
        check_val(repeatDone, 31'(r));
        check_val(len >= 2 * MS - 1 && len <= 2 * MS + 1, 1'b1);
        check_val(runStatus && servoOn, 1'b1);
        press();
        check_val(servoOn, 1'b0);
        tick(1);
        enterFunction <= 1'b0;
        tick(4);
    endtask
    task automatic finish_test;
        $display("mismatches %0d, checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #1000000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
    initial
    begin
        tick(4);
        mid;
        check_val(moveDistance, 31'h00008000);
        check_val(moveSpeed, 14'h0032);
        check_val(moveRamp, 14'h0064);
        tick(1);
        rstn <= 1'b1;
        tick(6);
        jogMoveDistance <= 31'h00000000;
        jogMoveSpeed <= 14'h0000;
        jogRampTime <= 14'h0000;
        tick(4);
        mid;
        check_val(moveDistance, 31'h00000001);
        check_val(moveSpeed, 14'h0001);
        check_val(moveRamp, 14'h0002);
        tick(1);
        jogMoveDistance <= 31'h7fffffff;
        jogMoveSpeed <= 14'h3fff;
        jogRampTime <= 14'h3fff;
        tick(4);
        mid;
        check_val(moveDistance, 31'h40000000);
        check_val(moveSpeed, 14'h2710);
        check_val(moveRamp, 14'h2710);
        tick(1);
        jogMoveDistance <= 31'h00000064;
        jogMoveSpeed <= 14'h0010;
        jogRampTime <= 14'h0002;
        writeProtect <= 1'b1;
        enterFunction <= 1'b1;
        tick(6);
        mid;
        check_val(noOpStatus, 1'b1);
        check_val(functionActive, 1'b0);
        tick(1);
        writeProtect <= 1'b0;
        enterFunction <= 1'b0;
        servoReady <= 1'b0;
        tick(4);
        enterFunction <= 1'b1;
        tick(6);
        press();
        check_val(servoOn, 1'b0);
        tick(1);
        enterFunction <= 1'b0;
        servoReady <= 1'b1;
        tick(4);
        for (int p = 0; p < 6; p++)
        begin
            directionSelect <= p[1];
            begin_run(p[2:0], 16'h0002);
            finish_run(p[2:0], p < 2 ? 2 : 4, 2);
        end
        begin_run(3'h2, 16'h0000);
        finish_run(3'h2, 2, 1);
        fwdOvertravel <= 1'b1;
        begin_run(3'h0, 16'h0001);
        tick(1);
        absEncoder <= 1'b0;
        tick(39);
        mid;
        check_val(31'(q.size()), 31'h0);
        check_val(sensorOnOut, 1'b0);
        tick(1);
        fwdOvertravel <= 1'b0;
        absEncoder <= 1'b1;
        finish_run(3'h0, 1, 1);
        doneDelay <= 8'h14;
        begin_run(3'h4, 16'h0000);
        wait_moves(7);
        check_dirs(3'h4, 7);
        check_val(endStatus, 1'b0);
        stopSeen = 1'b0;
        press();
        check_val(stopSeen, 1'b1);
        check_val(servoOn, 1'b0);
        finish_test();
    end
endmodule
bind program_jog_sequencer program_jog_sequencer_checker i_chk (
    .core_clk, .rstn, .fwdOvertravel, .revOvertravel, .directionSelect,
    .moveStart, .moveDirUp, .moveDistance, .moveSpeed, .moveRamp,
    .moveStop, .servoOn, .functionActive, .noOpStatus, .endStatus,
    .runStatus
);
`default_nettype wire
